// ==== pkg/host_port_regs.vh ====
// Constants for the byte-wide host port: offsets, fields, resets and timing
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH
`define HP_OFF_IND_ADDR 2'h0
`define HP_OFF_IND_DATA 2'h1
`define HP_OFF_FIFO 2'h2
`define HP_OFF_STATUS 2'h3
`define HP_IRQ_CFG_ADDR 8'hC2
`define HP_IRQ_CFG_PUSHPULL_BIT 0
`define HP_SLOW_LAST 8'h8F
`define HP_FAST_LAST 8'hCF
`define HP_STAT_CYCLE_DONE_BIT 0
`define HP_RESET_BYTE 8'h00
`define HP_SYNC_STAGES 2
`define HP_SLOW_LAT_US 64
`define HP_CLK_MHZ 50
`define HP_SLOW_LAT_CYCLES (`HP_SLOW_LAT_US * `HP_CLK_MHZ)
`endif

// ==== src/host_port.v ====
// Byte-wide asynchronous host port with indirect register access
// Behaviour
// - Direction line high means read, low means write; device samples it.
// - Device drives ready low as soon as a cycle starts.
// - Device releases ready once write taken or read data is valid.
// - Interrupt open-drain active low by default; indirect C2 selects push-pull high.
// - Four host byte registers selected by two address lines.
// - Write at address 00 loads the indirect address register.
// - Write at address 01 writes the internal register selected indirectly.
// - Read at address 01 returns the internal register selected indirectly.
// - Read at address 10 pops the next sliced FIFO byte.
// - Address 11 reads or writes the status/interrupt register directly.
// - Status register shows the state of every interrupt source.
// - Writing one to a status bit clears that condition.
// - Indirect 00 to 8F may take up to 64 us; cycle-complete flags it.
// - Indirect 90 to CF finish quickly and raise no cycle-complete event.
`timescale 1ns/10ps
`include "host_port_regs.vh"
`default_nettype none
module host_port #(
   parameter SLOW_LAT_CYCLES = `HP_SLOW_LAT_CYCLES
) (
   input wire I_CLK,
   input wire I_RST,
   input wire I_STROBE_MODE,
   input wire I_CS_N,
   input wire [1:0] I_HOST_ADDRESS,
   input wire [7:0] I_HOST_BYTE_BUS,
   input wire I_RD_N,
   input wire I_WR_N,
   input wire I_CYCLE_STROBE_N,
   input wire I_RD_WR,
   output reg [7:0] O_HOST_BYTE_BUS,
   output wire O_HOST_BYTE_BUS_OE,
   output wire O_READY,
   output wire O_READY_OE,
   output wire O_IRQ_OUT,
   output wire O_IRQ_OUT_OE,
   output reg O_INT_REQ,
   output reg O_INT_WE,
   output reg [7:0] O_INT_ADDR,
   output reg [7:0] O_INT_WDATA,
   input wire [7:0] I_INT_RDATA,
   input wire I_INT_DONE,
   input wire [7:0] I_FIFO_DATA,
   input wire I_FIFO_VALID,
   output reg O_FIFO_POP,
   input wire [7:1] I_IRQ_SOURCES,
   input wire [7:0] I_IRQ_ENABLE
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers: all host pins are asynchronous to I_CLK
reg [4:0] s1_reg;
reg [4:0] s2_reg;
reg [1:0] a_s1_reg, a_s2_reg;
reg [7:0] d_s1_reg, d_s2_reg;
reg mode_s1_reg, mode_s2_reg;
// Mode strap is synchronised too: it may be rewired between host cycles
always @(posedge I_CLK) begin
   mode_s1_reg <= I_STROBE_MODE;
   mode_s2_reg <= mode_s1_reg;
   s1_reg <= {I_CS_N, I_RD_N, I_WR_N, I_CYCLE_STROBE_N, I_RD_WR};
   s2_reg <= s1_reg;
   a_s1_reg <= I_HOST_ADDRESS;
   a_s2_reg <= a_s1_reg;
   d_s1_reg <= I_HOST_BYTE_BUS;
   d_s2_reg <= d_s1_reg;
end

wire cs_n = s2_reg[4];
wire rd_active = mode_s2_reg ? (!s2_reg[1] && s2_reg[0]) : !s2_reg[3];
wire wr_active = mode_s2_reg ? (!s2_reg[1] && !s2_reg[0]) : !s2_reg[2];
// Cycle is live while selected and either strobe low
wire cyc_on = !cs_n && (rd_active || wr_active);

////////////////////////////////////////////////////////////////////////////////
// Handshake state machine
localparam ST_IDLE = 2'h0;
localparam ST_WAIT = 2'h1;
localparam ST_DONE = 2'h2;
reg [1:0] state_reg;
reg [7:0] ind_addr_reg;
reg [7:0] status_reg;
reg irq_pushpull_reg;
reg is_read_reg;
// Latency counter is for debug only; the done input alone ends an indirect data wait
reg [15:0] lat_cnt_reg;
wire in_slow = (ind_addr_reg <= `HP_SLOW_LAST);
wire in_irqcfg = (ind_addr_reg == `HP_IRQ_CFG_ADDR);
reg done_pulse;
reg [7:0] clr_mask;

// Ready is pulled low except when idle or done; done releases it
// Direct registers still pull ready low for one cycle, so every cycle is answered
assign O_READY = 1'b0;
assign O_READY_OE = (state_reg == ST_WAIT);
assign O_HOST_BYTE_BUS_OE = is_read_reg && (state_reg != ST_IDLE) && cyc_on;

always @(posedge I_CLK) begin
   if (I_RST) begin
      state_reg <= ST_IDLE;
      ind_addr_reg <= `HP_RESET_BYTE;
      irq_pushpull_reg <= 1'b0;
      is_read_reg <= 1'b0;
      O_HOST_BYTE_BUS <= `HP_RESET_BYTE;
      O_INT_REQ <= 1'b0;
      O_INT_WE <= 1'b0;
      O_INT_ADDR <= `HP_RESET_BYTE;
      O_INT_WDATA <= `HP_RESET_BYTE;
      O_FIFO_POP <= 1'b0;
      lat_cnt_reg <= 16'h0000;
      done_pulse <= 1'b0;
      clr_mask <= 8'h00;
   end else begin
      O_INT_REQ <= 1'b0;
      O_FIFO_POP <= 1'b0;
      done_pulse <= 1'b0;
      clr_mask <= 8'h00;
      case (state_reg)
         ST_IDLE: begin
            if (cyc_on) begin
               state_reg <= ST_WAIT;
               is_read_reg <= rd_active;
               lat_cnt_reg <= 16'h0000;
               // Every register passes through the wait state, so ready goes low
               // Two address lines pick one of four byte registers
               case (a_s2_reg)
                  `HP_OFF_IND_ADDR: begin
                     if (wr_active) begin
                        ind_addr_reg <= d_s2_reg;
                     end
                  end
                  `HP_OFF_IND_DATA: begin
                     O_INT_REQ <= 1'b1;
                     O_INT_WE <= wr_active;
                     O_INT_ADDR <= ind_addr_reg;
                     O_INT_WDATA <= d_s2_reg;
                     if (wr_active && in_irqcfg) begin
                        irq_pushpull_reg <= d_s2_reg[`HP_IRQ_CFG_PUSHPULL_BIT];
                     end
                  end
                  `HP_OFF_FIFO: begin
                     // Pop is left to the wait state, where valid is seen
                  end
                  default: begin
                     if (rd_active) begin
                        O_HOST_BYTE_BUS <= status_reg;
                     end else begin
                        clr_mask <= d_s2_reg;
                     end
                  end
               endcase
            end
         end
         ST_WAIT: begin
            lat_cnt_reg <= lat_cnt_reg + 16'h0001;
            case (a_s2_reg)
               `HP_OFF_FIFO: begin
                  if (!is_read_reg) begin
                     // Writes to the read-only FIFO port are dropped
                     state_reg <= ST_DONE;
                  end else if (I_FIFO_VALID) begin
                     // Hold ready low until the FIFO has a byte to give
                     O_HOST_BYTE_BUS <= I_FIFO_DATA;
                     O_FIFO_POP <= 1'b1;
                     state_reg <= ST_DONE;
                  end
               end
               `HP_OFF_IND_DATA: begin
                  // A slow internal access stretches the host cycle
                  if (I_INT_DONE) begin
                     if (is_read_reg) begin
                        O_HOST_BYTE_BUS <= I_INT_RDATA;
                     end
                     done_pulse <= in_slow;
                     state_reg <= ST_DONE;
                  end
               end
               default: begin
                  // Direct registers were served on entry; one cycle of low ready
                  state_reg <= ST_DONE;
               end
            endcase
         end
         ST_DONE: begin
            // Wait for the host to raise its strobe before next cycle
            if (!cyc_on) begin
               state_reg <= ST_IDLE;
            end
         end
         default: begin
            state_reg <= ST_IDLE;
         end
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////////
// Status: bit 0 sticky cycle-complete, upper bits sticky sources held until cleared
always @(posedge I_CLK) begin
   if (I_RST) begin
      status_reg <= 8'h00;
   end else begin
      // Set beats clear in the same cycle
      status_reg[`HP_STAT_CYCLE_DONE_BIT] <= done_pulse ||
         (status_reg[`HP_STAT_CYCLE_DONE_BIT] && !clr_mask[`HP_STAT_CYCLE_DONE_BIT]);
      status_reg[7:1] <= I_IRQ_SOURCES | (status_reg[7:1] & ~clr_mask[7:1]);
   end
end

wire irq_any = |(status_reg & I_IRQ_ENABLE);
// Open drain drives low only; push-pull drives high when active
assign O_IRQ_OUT = irq_pushpull_reg ? irq_any : 1'b0;
assign O_IRQ_OUT_OE = irq_pushpull_reg ? 1'b1 : irq_any;

endmodule // host_port
`default_nettype wire

// ==== verif/host_port_sva.sv ====
// Assertions on the host port handshake and internal forwarding
`timescale 1ns/10ps
`default_nettype none
module host_port_sva (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_STROBE_MODE,
   input wire logic I_CS_N,
   input wire logic [1:0] I_HOST_ADDRESS,
   input wire logic I_RD_N,
   input wire logic I_WR_N,
   input wire logic I_CYCLE_STROBE_N,
   input wire logic I_RD_WR,
   input wire logic O_READY,
   input wire logic O_READY_OE,
   input wire logic O_IRQ_OUT,
   input wire logic O_IRQ_OUT_OE,
   input wire logic O_INT_REQ,
   input wire logic O_INT_WE,
   input wire logic I_INT_DONE,
   input wire logic O_FIFO_POP
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   // Ready is only pulled low, the pullup makes the high level
   a_ready_low: assert property (O_READY_OE |-> !O_READY) else $error("ready high");
   // Two synchroniser stages and the idle decision put ready low three edges on
   a_ready_drop: assert property (!I_CS_N && (I_STROBE_MODE ? $fell(I_CYCLE_STROBE_N)
      : ($fell(I_RD_N) || $fell(I_WR_N))) |-> ##3 O_READY_OE) else $error("ready not driven");
   a_wait_hold: assert property (O_READY_OE && I_HOST_ADDRESS == 2'h1 && !I_INT_DONE
      |=> O_READY_OE) else $error("ready early");
   a_req_start: assert property ($rose(O_READY_OE) && I_HOST_ADDRESS == 2'h1
      |-> O_INT_REQ) else $error("no request");
   a_req_pulse: assert property (O_INT_REQ |=> !O_INT_REQ) else $error("long request");
   a_done_free: assert property (I_INT_DONE && O_READY_OE |=> !O_READY_OE) else $error("stuck");
   a_irq_drive: assert property (O_IRQ_OUT |-> O_IRQ_OUT_OE) else $error("irq float");
   a_pop_addr: assert property (O_FIFO_POP |-> I_HOST_ADDRESS == 2'h2) else $error("bad pop");
   a_we_dir: assert property (O_INT_REQ
      |-> O_INT_WE == (I_STROBE_MODE ? !I_RD_WR : !I_WR_N)) else $error("bad direction");
   // Main scenarios reached
   c_slow: cover property (O_READY_OE [*8]);
   c_pop: cover property (O_FIFO_POP);
   c_irq: cover property (O_IRQ_OUT && O_IRQ_OUT_OE);
endmodule // host_port_sva
bind host_port host_port_sva u_sva (.I_CLK(I_CLK), .I_RST(I_RST),
   .I_STROBE_MODE(I_STROBE_MODE), .I_CS_N(I_CS_N), .I_HOST_ADDRESS(I_HOST_ADDRESS),
   .I_RD_N(I_RD_N), .I_WR_N(I_WR_N), .I_CYCLE_STROBE_N(I_CYCLE_STROBE_N), .I_RD_WR(I_RD_WR),
   .O_READY(O_READY), .O_READY_OE(O_READY_OE), .O_IRQ_OUT(O_IRQ_OUT),
   .O_IRQ_OUT_OE(O_IRQ_OUT_OE), .O_INT_REQ(O_INT_REQ), .O_INT_WE(O_INT_WE),
   .I_INT_DONE(I_INT_DONE), .O_FIFO_POP(O_FIFO_POP));
`default_nettype wire

// ==== verif/int_side_model.sv ====
// Behavioural internal register file and sliced FIFO behind the port
`timescale 1ns/10ps
`default_nettype none
module int_side_model (
   input wire logic clk,
   input wire logic req,
   input wire logic we,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] lat,
   input wire logic pop,
   output logic [7:0] rdata,
   output logic done,
   output logic [7:0] fdata
);
   logic [7:0] mem [0:255];
   logic [7:0] cnt = 8'h00;
   initial fdata = 8'h40;
   initial done = 1'b0;
   // Inverse outside the done pulse so stale data never matches
   assign rdata = done ? mem[addr] : ~mem[addr];
   // Latency set per scenario, prompt or slow
   always @(posedge clk) begin
      done <= cnt == 8'h01;
      if (cnt == 8'h01 && we)
         mem[addr] <= wdata;
      if (pop)
         fdata <= fdata + 8'h01;
      if (req)
         cnt <= lat;
      else if (cnt != 8'h00)
         cnt <= cnt - 8'h01;
   end
endmodule // int_side_model
`default_nettype wire

// ==== verif/tb_host_port.sv ====
// Self-checking bench for the host port
`timescale 1ns/10ps
`default_nettype none
module tb_host_port;
   logic clk = 0, rst = 1, mode = 0, cs_n = 1, rd_n = 1, wr_n = 1, ds_n = 1, rw = 1;
   logic [1:0] ha = 2'h0;
   logic [7:0] hd = 8'h00, lat = 8'h01;
   logic [6:0] src = 7'h00;
   logic [7:0] ien = 8'hFF;
   wire logic req, we, done, pop, roe, irq, ioe, boe, rdy;
   wire logic [7:0] iaddr, iwdata, rdata, fdata, hbus;
   int n_errors = 0, samples_checked = 0;
   host_port #(.SLOW_LAT_CYCLES(16)) uut (.I_CLK(clk), .I_RST(rst), .I_STROBE_MODE(mode),
      .I_CS_N(cs_n), .I_HOST_ADDRESS(ha), .I_HOST_BYTE_BUS(hd), .I_RD_N(rd_n), .I_WR_N(wr_n),
      .I_CYCLE_STROBE_N(ds_n), .I_RD_WR(rw), .O_HOST_BYTE_BUS(hbus), .O_HOST_BYTE_BUS_OE(boe),
      .O_READY(rdy), .O_READY_OE(roe), .O_IRQ_OUT(irq), .O_IRQ_OUT_OE(ioe), .O_INT_REQ(req),
      .O_INT_WE(we), .O_INT_ADDR(iaddr), .O_INT_WDATA(iwdata), .I_INT_RDATA(rdata),
      .I_INT_DONE(done), .I_FIFO_DATA(fdata), .I_FIFO_VALID(1'b1), .O_FIFO_POP(pop),
      .I_IRQ_SOURCES(src), .I_IRQ_ENABLE(ien));
   int_side_model m (.clk(clk), .req(req), .we(we), .addr(iaddr), .wdata(iwdata), .lat(lat),
      .pop(pop), .rdata(rdata), .done(done), .fdata(fdata));
   initial forever #10 clk = ~clk;
   task automatic wrap_up;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("[FAIL] %s exp %h got %h", nm, e, g);
         n_errors++;
      end
   endtask
   // One host cycle; selects and data settle a cycle before the strobe
   task automatic cyc(input logic rd, input logic [1:0] a, input logic [7:0] d,
      output logic [7:0] q);
      int k;
      @(posedge clk);
      cs_n <= 1'b0;
      ha <= a;
      hd <= d;
      rw <= rd;
      @(posedge clk);
      if (mode) ds_n <= 1'b0;
      else if (rd) rd_n <= 1'b0;
      else wr_n <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("ready low", 8'h01, {6'h00, rdy, roe});
      for (k = 0; roe !== 1'b0 && k < 500; k++) @(negedge clk);
      q = hbus;
      chk("data drive", {7'h00, rd}, {7'h00, boe});
      if (k == 500) begin
         chk("ready release", 8'h00, {7'h00, roe});
         wrap_up;
      end
      @(posedge clk);
      ds_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      cs_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   task automatic t_indirect(input logic md, input logic [7:0] l, a, d);
      logic [7:0] q;
      mode <= md;
      lat <= l;
      cyc(0, 2'h0, a, q);
      cyc(0, 2'h1, d, q);
      cyc(0, 2'h0, a, q);
      cyc(1, 2'h1, 8'h00, q);
      chk("indirect data", d, q);
   endtask
   task automatic t_status;
      logic [7:0] q;
      cyc(1, 2'h3, 8'h00, q);
      chk("status done bit", 8'h01, q);
      cyc(0, 2'h3, 8'hFF, q);
      t_indirect(1, 8'h01, 8'h95, 8'h3C);
      cyc(1, 2'h3, 8'h00, q);
      chk("status after fast", 8'h00, q);
      src <= 7'h04;
      cyc(1, 2'h3, 8'h00, q);
      chk("status source", 8'h08, q);
      chk("irq open drain", 8'h02, {6'h00, ioe, irq});
      ien <= 8'h00;
      @(posedge clk);
      @(negedge clk);
      chk("irq masked", 8'h00, {6'h00, ioe, irq});
      @(posedge clk);
      ien <= 8'hFF;
      cyc(0, 2'h0, 8'hC2, q);
      cyc(0, 2'h1, 8'h01, q);
      chk("irq push pull", 8'h03, {6'h00, ioe, irq});
      src <= 7'h00;
      cyc(0, 2'h3, 8'h08, q);
      cyc(1, 2'h3, 8'h00, q);
      chk("status cleared", 8'h00, q);
   endtask
   task automatic t_fifo;
      logic [7:0] q, e;
      e = fdata;
      cyc(1, 2'h2, 8'h00, q);
      chk("fifo first", e, q);
      cyc(0, 2'h2, 8'h55, q);
      cyc(1, 2'h2, 8'h00, q);
      chk("fifo next", e + 8'h01, q);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      t_indirect(0, 8'h1E, 8'h12, 8'hA5);
      t_status;
      t_fifo;
      wrap_up;
   end
endmodule // tb_host_port
`default_nettype wire
